//--- hdl/swp_write_protect.sv
`timescale 1ns/1ps
`include "swp_params.svh"
module swp_write_protect
  import swp_pkg::*;
#(
  parameter int WRITE_CYCLES = `SWP_WRITE_TIME_NS / `SWP_CLK_PERIOD_NS
) (
  input wire logic sys_clk, // 200 MHz clock
  input wire logic srst, // Sync reset, power-up
  input wire logic sel_n_pin, // Chip select, active low
  input wire logic sclk_pin, // Serial clock
  input wire logic sdi_pin, // Serial data in
  input wire logic wprot_n_pin, // Write-protect, active low
  output logic sdo_out, // Serial data out
  output logic sdo_oe, // Data out enable
  output logic [7:0] status_q, // Status register view
  output logic array_wr_q, // Array write accepted pulse
  output logic [7:0] array_addr_q, // Address of last array write, accepted or refused
  output logic array_blocked_q // Array write refused pulse
);
  logic [2:0] sel_s_q, clk_s_q, dat_s_q, wp_s_q;
  swp_state_type state_q;
  logic [7:0] op_q, addr_q, shift_q;
  logic [5:0] nbits_q;
  logic latch_q, sel_hi_q, sel_lo_q, busy_q, is_array_q;
  logic [22:0] wcnt_q;
  logic [1:0] sync_fill_q;
  logic sel_seen_hi_q;
  logic [2:0] bitpos_q;
  logic sel_fall, sel_rise, clk_rise, wp_ok, sr_writable, addr_prot, byte_done, op_match;
  logic status_go, array_go;

  // Stage 0 feeds stage 1 only; edges seen from stages 1 and 2
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      sel_s_q <= 3'h7;
      clk_s_q <= 3'h0;
      dat_s_q <= 3'h0;
      wp_s_q <= 3'h0;
    end else begin
      sel_s_q <= {sel_s_q[1:0], sel_n_pin};
      clk_s_q <= {clk_s_q[1:0], sclk_pin};
      dat_s_q <= {dat_s_q[1:0], sdi_pin};
      wp_s_q <= {wp_s_q[1:0], wprot_n_pin};
    end
  end

  // Reset value of the select stages is no real sample; arm only on a seen high
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      sync_fill_q <= 2'h0;
      sel_seen_hi_q <= 1'b0;
    end else begin
      sync_fill_q <= {sync_fill_q[0], 1'b1};
      if (sync_fill_q[1] && sel_s_q[1]) sel_seen_hi_q <= 1'b1;
    end
  end

  // A select already low at power-up never counts as a fall
  assign sel_fall = sel_seen_hi_q && sel_s_q[2] && !sel_s_q[1];
  assign sel_rise = !sel_s_q[2] && sel_s_q[1];
  assign clk_rise = !clk_s_q[2] && clk_s_q[1] && !sel_s_q[1];
  assign wp_ok = wp_s_q[1];
  assign sr_writable = wp_ok && latch_q;
  always_comb begin
    case ({sel_hi_q, sel_lo_q})
      2'b00: addr_prot = 1'b0;
      2'b01: addr_prot = addr_q >= `SWP_PROT_QUARTER;
      2'b10: addr_prot = addr_q >= `SWP_PROT_HALF;
      default: addr_prot = 1'b1;
    endcase
  end
  assign byte_done = bitpos_q == `SWP_BYTE_LOW_BITS;
  assign op_match = (op_q & `SWP_OP_MASK) == `SWP_OP_STATUS_STORE;
  assign status_go = sel_rise && (state_q == SWP_ACTIVE) && op_match && nbits_q == `SWP_BITS_STATUS;
  // Array data bytes follow opcode and address; page wrap is the array's concern
  assign array_go = sel_rise && (state_q == SWP_ACTIVE) && is_array_q && byte_done
                    && nbits_q > `SWP_BITS_ADDR;

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      state_q <= SWP_IDLE;
    end else begin
      case (state_q)
        SWP_IDLE: if (sel_fall) state_q <= SWP_ACTIVE;
        SWP_ACTIVE: begin
          if ((status_go && sr_writable) || (array_go && sr_writable && !addr_prot)) begin
            state_q <= SWP_BUSY;
          end else if (sel_rise) begin
            state_q <= SWP_IDLE;
          end
        end
        SWP_BUSY: if (wcnt_q == 23'h0) state_q <= SWP_IDLE;
        default: state_q <= SWP_IDLE;
      endcase
    end
  end

  // Bit shifting; latch commands are still decoded while busy, status and array writes are not
  always_ff @(posedge sys_clk) begin
    if (srst || sel_s_q[1]) begin
      nbits_q <= 6'h0;
      op_q <= 8'h0;
      addr_q <= 8'h0;
      shift_q <= 8'h0;
      bitpos_q <= 3'h0;
    end else if (clk_rise && state_q != SWP_IDLE) begin
      shift_q <= {shift_q[6:0], dat_s_q[1]};
      // Bit count saturates; byte position kept apart so long page frames still end on a byte
      bitpos_q <= bitpos_q + 3'h1;
      if (nbits_q != 6'h3F) nbits_q <= nbits_q + 6'h1;
      if (nbits_q < `SWP_BITS_OP) op_q <= {op_q[6:0], dat_s_q[1]};
      else if (nbits_q < `SWP_BITS_ADDR) addr_q <= {addr_q[6:0], dat_s_q[1]};
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) is_array_q <= 1'b0;
    else is_array_q <= (op_q & `SWP_OP_MASK) == `SWP_OP_ARRAY_WRITE && state_q == SWP_ACTIVE;
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      latch_q <= 1'b0;
    end else if (!wp_ok) begin
      latch_q <= 1'b0;
    end else if (state_q == SWP_BUSY && wcnt_q == 23'h0) begin
      latch_q <= 1'b0;
    end else if (sel_rise && state_q != SWP_IDLE && nbits_q == `SWP_BITS_OP) begin
      if ((op_q & `SWP_OP_MASK) == `SWP_OP_LATCH_SET) latch_q <= 1'b1;
      if ((op_q & `SWP_OP_MASK) == `SWP_OP_LATCH_CLEAR) latch_q <= 1'b0;
    end
  end

  // Protect bits model nonvolatile cells; reset value stands for erased cells
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      sel_hi_q <= 1'b0;
      sel_lo_q <= 1'b0;
    end else if (status_go && sr_writable && state_q == SWP_ACTIVE) begin
      sel_hi_q <= shift_q[`SWP_SEL_HI_POS];
      sel_lo_q <= shift_q[`SWP_SEL_LO_POS];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) wcnt_q <= 23'h0;
    else if (state_q == SWP_ACTIVE) wcnt_q <= 23'(WRITE_CYCLES - 1);
    else if (state_q == SWP_BUSY && wcnt_q != 23'h0) wcnt_q <= wcnt_q - 23'h1;
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      busy_q <= 1'b0;
      status_q <= 8'h0;
      array_wr_q <= 1'b0;
      array_addr_q <= 8'h0;
      array_blocked_q <= 1'b0;
      sdo_out <= 1'b0;
      sdo_oe <= 1'b0;
    end else begin
      busy_q <= state_q == SWP_BUSY;
      status_q <= {4'h0, sel_hi_q, sel_lo_q, latch_q, state_q == SWP_BUSY};
      array_wr_q <= array_go && state_q == SWP_ACTIVE && sr_writable && !addr_prot;
      array_blocked_q <= array_go && state_q == SWP_ACTIVE && !(sr_writable && !addr_prot);
      if (array_go) array_addr_q <= addr_q;
      sdo_out <= 1'b0;
      sdo_oe <= 1'b0;
    end
  end

  // Output pulses and status view move together, so checks compare them in one cycle
  chk_latch_wp: assert property (@(posedge sys_clk) disable iff (srst)
    !wp_s_q[1] |=> !latch_q) else $error("latch set while protect pin low");
  chk_latch_end: assert property (@(posedge sys_clk) disable iff (srst)
    $fell(busy_q) |-> !latch_q) else $error("latch not cleared after write");
  chk_prot_all: assert property (@(posedge sys_clk) disable iff (srst)
    array_wr_q |-> !(status_q[3] && status_q[2])) else $error("write into fully protected array");
  chk_prot_quarter: assert property (@(posedge sys_clk) disable iff (srst)
    (array_wr_q && status_q[3:2] == 2'b01) |-> array_addr_q < `SWP_PROT_QUARTER) else $error("quarter breached");
  chk_prot_half: assert property (@(posedge sys_clk) disable iff (srst)
    (array_wr_q && status_q[3:2] == 2'b10) |-> array_addr_q < `SWP_PROT_HALF) else $error("half breached");
  chk_wr_needs: assert property (@(posedge sys_clk) disable iff (srst)
    array_wr_q |-> $past(latch_q) && $past(wp_s_q[1])) else $error("write without enable");
  chk_sel_stable: assert property (@(posedge sys_clk) disable iff (srst)
    (state_q == SWP_BUSY && !status_go) |=> $stable(sel_hi_q)) else $error("protect bits changed busy");
  chk_idle_leave: assert property (@(posedge sys_clk) disable iff (srst)
    (state_q == SWP_IDLE && !sel_fall) |=> state_q == SWP_IDLE) else $error("left idle without select");
  chk_sdo_off: assert property (@(posedge sys_clk) disable iff (srst)
    !sdo_oe) else $error("data out driven");
  chk_busy_flag: assert property (@(posedge sys_clk) disable iff (srst)
    status_q[0] == $past(state_q == SWP_BUSY)) else $error("busy flag wrong");
  chk_sr_refused: assert property (@(posedge sys_clk) disable iff (srst)
    (status_go && !sr_writable) |=> state_q != SWP_BUSY) else $error("refused status write ran");
  chk_status_commit: assert property (@(posedge sys_clk) disable iff (srst)
    (state_q == SWP_ACTIVE && status_go && sr_writable) |=> state_q == SWP_BUSY) else $error("status write not started");
  chk_busy_hold: assert property (@(posedge sys_clk) disable iff (srst)
    (state_q == SWP_BUSY && wcnt_q != 23'h0) |=> state_q == SWP_BUSY) else $error("write cycle cut short");
  chk_start_edge: assert property (@(posedge sys_clk) disable iff (srst)
    $rose(busy_q) |-> $past(sel_rise, 2)) else $error("write started without deselect");
  // Main scenarios
  cov_status: cover property (@(posedge sys_clk) status_go && sr_writable);
  cov_array: cover property (@(posedge sys_clk) array_wr_q);
  cov_block: cover property (@(posedge sys_clk) array_blocked_q);
  cov_busy_frame: cover property (@(posedge sys_clk) state_q == SWP_BUSY && sel_rise);
endmodule // swp_write_protect

//--- pkg/swp_params.svh
`ifndef SWP_PARAMS_SVH
`define SWP_PARAMS_SVH
`define SWP_OP_MASK 8'hF7
`define SWP_OP_STATUS_STORE 8'h01
`define SWP_OP_LATCH_SET 8'h06
`define SWP_OP_LATCH_CLEAR 8'h04
`define SWP_OP_ARRAY_WRITE 8'h02
`define SWP_BITS_OP 6'h08
`define SWP_BITS_STATUS 6'h10
`define SWP_BITS_ADDR 6'h10
`define SWP_BYTE_LOW_BITS 3'h0
`define SWP_PROT_QUARTER 8'hC0
`define SWP_PROT_HALF 8'h80
`define SWP_SEL_HI_POS 3
`define SWP_SEL_LO_POS 2
`define SWP_WRITE_TIME_NS 5000000
`define SWP_CLK_PERIOD_NS 5
`endif

//--- pkg/swp_pkg.sv
package swp_pkg;
  typedef enum logic [1:0] {SWP_IDLE, SWP_ACTIVE, SWP_BUSY} swp_state_type;
endpackage

//--- test/swp_host_model.sv
`timescale 1ns/1ps
module swp_host_model (
  input wire logic sys_clk, // Bench clock
  output logic sel_n, // Chip select, active low
  output logic sclk, // Serial clock
  output logic sdi // Serial data
);
  initial begin
    sel_n = 1'b1;
    sclk = 1'b0;
    sdi = 1'b0;
  end
  task automatic wait_clk(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  task automatic select_level(input logic level);
    sel_n <= level;
  endtask
  // Clock idles low between frames, 160 ns period
  task automatic frame(input logic [23:0] data, input int nbits);
    sel_n <= 1'b0;
    for (int i = nbits - 1; i >= 0; i--) begin
      sdi <= data[i];
      wait_clk(16);
      sclk <= 1'b1;
      wait_clk(16);
      sclk <= 1'b0;
    end
    wait_clk(16);
    sel_n <= 1'b1;
    sdi <= ~sdi;
    wait_clk(8);
  endtask
endmodule // swp_host_model

//--- test/swp_write_protect_tb.sv
`timescale 1ns/1ps
module swp_write_protect_tb;
  import swp_pkg::*;
  logic sys_clk, srst, wprot_n_pin, sdo_out, sdo_oe, array_wr_q, array_blocked_q, wr_seen, blk_seen;
  logic sel_n, sclk, sdi;
  logic [7:0] status_q, array_addr_q;
  int fails = 0;
  int checks_done = 0;
  int cycles = 0;
  swp_host_model host_u (.sys_clk(sys_clk), .sel_n(sel_n), .sclk(sclk), .sdi(sdi));
  // Write cycle longer than a whole frame, so a frame can land inside it
  localparam int WRITE_CYCLES = 1000;
  swp_write_protect #(.WRITE_CYCLES(WRITE_CYCLES)) dut_u (.sys_clk(sys_clk), .srst(srst), .sel_n_pin(sel_n),
    .sclk_pin(sclk), .sdi_pin(sdi), .wprot_n_pin(wprot_n_pin), .sdo_out(sdo_out), .sdo_oe(sdo_oe),
    .status_q(status_q), .array_wr_q(array_wr_q), .array_addr_q(array_addr_q),
    .array_blocked_q(array_blocked_q));
  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end
  // Pulses last one cycle, so latch them for the scenario
  always @(posedge sys_clk) begin
    cycles++;
    if (array_wr_q === 1'b1) wr_seen <= 1'b1;
    if (array_blocked_q === 1'b1) blk_seen <= 1'b1;
    if (cycles == 40000) begin
      fails++;
      final_report();
    end
  end
  task automatic final_report();
    $display("checks %0d fails %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic test_latch_cmds();
    check(status_q, 8'h00);
    check({6'h00, sdo_oe, sdo_out}, 8'h00);
    host_u.frame(24'h00010C, 16);
    check(status_q, 8'h00);
    host_u.frame(24'h00000E, 8);
    check(status_q, 8'h02);
    host_u.frame(24'h000004, 8);
    check(status_q, 8'h00);
    $display("test_latch_cmds done");
  endtask
  task automatic status_write(input logic [1:0] sel);
    host_u.frame(24'h000006, 8);
    host_u.frame({8'h00, 8'h09, 4'hF, sel, 2'b11}, 16);
    check(status_q, {4'h0, sel, 2'b11});
    host_u.wait_clk(WRITE_CYCLES + 100);
    check(status_q, {4'h0, sel, 2'b00});
    $display("status_write done");
  endtask
  task automatic array_write(input logic [7:0] addr, input logic ok);
    host_u.frame(24'h000006, 8);
    wr_seen <= 1'b0;
    blk_seen <= 1'b0;
    host_u.frame({8'h02, addr, 8'h5A}, 24);
    check({6'h00, wr_seen, blk_seen}, {6'h00, ok, !ok});
    if (ok) check(array_addr_q, addr);
    host_u.wait_clk(WRITE_CYCLES + 100);
    $display("array_write done");
  endtask
  task automatic test_busy_access();
    host_u.frame(24'h000006, 8);
    host_u.frame(24'h000100, 16);
    wr_seen <= 1'b0;
    blk_seen <= 1'b0;
    host_u.frame({8'h02, 8'h10, 8'hA5}, 24);
    check({6'h00, wr_seen, blk_seen}, 8'h00);
    check(status_q, 8'h03);
    host_u.wait_clk(WRITE_CYCLES + 100);
    check(status_q, 8'h00);
    $display("test_busy_access done");
  endtask
  task automatic test_reset_low_sel();
    host_u.select_level(1'b0);
    srst <= 1'b1;
    host_u.wait_clk(5);
    srst <= 1'b0;
    host_u.wait_clk(10);
    check(status_q, 8'h00);
    host_u.frame(24'h000006, 8);
    check(status_q, 8'h00);
    host_u.frame(24'h000006, 8);
    check(status_q, 8'h02);
    host_u.frame(24'h000004, 8);
    check(status_q, 8'h00);
    $display("test_reset_low_sel done");
  endtask
  task automatic test_count_and_pin();
    host_u.frame(24'h000006, 8);
    host_u.frame(24'h000086, 15);
    host_u.wait_clk(40);
    check(status_q, 8'h02);
    wprot_n_pin <= 1'b0;
    host_u.wait_clk(10);
    check(status_q, 8'h00);
    host_u.frame(24'h000006, 8);
    host_u.frame(24'h00010C, 16);
    host_u.wait_clk(40);
    check(status_q, 8'h00);
    wprot_n_pin <= 1'b1;
    $display("test_count_and_pin done");
  endtask
  initial begin
    srst = 1'b1;
    wprot_n_pin = 1'b1;
    wr_seen = 1'b0;
    blk_seen = 1'b0;
    host_u.wait_clk(20);
    srst <= 1'b0;
    host_u.wait_clk(10);
    test_latch_cmds();
    status_write(2'b01);
    array_write(8'hC0, 1'b0);
    array_write(8'hBF, 1'b1);
    status_write(2'b10);
    array_write(8'h80, 1'b0);
    array_write(8'h7F, 1'b1);
    status_write(2'b11);
    array_write(8'h00, 1'b0);
    status_write(2'b00);
    array_write(8'hFF, 1'b1);
    test_busy_access();
    test_reset_low_sel();
    test_count_and_pin();
    final_report();
  end
endmodule // swp_write_protect_tb
